// file: hdl/sswd_pkg.sv
// Purpose: Shared constants for the switch serial control and watchdog block
// Assumes: 200 MHz system clock
// Notes:   Timing counts derive from printed times and the clock rate
package sswd_pkg;
   localparam int unsigned CLOCK_HZ        = 200_000_000;
   localparam int unsigned WORD_BITS       = 16;
   localparam int unsigned NUM_OUT         = 12;
   localparam int unsigned NUM_HS          = 4;
   localparam int unsigned NUM_LS          = 8;
   localparam int unsigned WD_BIT_POS      = 15;
   localparam int unsigned HS_LSB          = 0;
   localparam int unsigned LS_LSB          = 4;
   // Least watchdog timeout in milliseconds
   localparam int unsigned WD_TIMEOUT_MS   = 340;
   localparam longint unsigned WD_TIMEOUT_CYCLES =
      (longint'(WD_TIMEOUT_MS) * longint'(CLOCK_HZ)) / 64'd1000;
   localparam logic [3:0]  FAILSAFE_HS_ON  = 4'h5;
   localparam logic [15:0] CMD_RESET       = 16'h0000;
   localparam logic [11:0] FAULT_RESET     = 12'h000;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [1:0]  SNS_FIRST       = 2'h0;
   localparam logic [1:0]  SNS_SECOND      = 2'h1;
   localparam logic [1:0]  SNS_SUM         = 2'h2;
   typedef enum logic [1:0] {SSWD_SLEEP, SSWD_NORMAL, SSWD_FAILSAFE} sswd_mode_type;
endpackage

// file: hdl/sswd_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sswd_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   initial
   begin
      if (WIDTH < 1) $error("WIDTH must be at least 1");
   end
   always_ff @(posedge clock)
   begin
      stage1 <= async_in;
      stage2 <= stage1;
   end
   assign sync_out = stage2;
endmodule
`default_nettype wire

// file: hdl/sswd_watchdog.sv
// Purpose: Watchdog timeout counter
// Assumes: Kick and start are single-cycle pulses on clock
// Notes:   Expire pulses once per timeout while enabled and unkicked
`timescale 1ns/1ps
`default_nettype none
module sswd_watchdog #(
   parameter longint unsigned TIMEOUT_CYCLES = 68_000_000
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic enable,
   input  wire logic restart,
   output logic      expire
);
   localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_expire;
   initial
   begin
      if (TIMEOUT_CYCLES < 2) $error("TIMEOUT_CYCLES too small");
   end
   always_comb
   begin
      next_count  = count;
      next_expire = 1'b0;
      if (!enable || restart)
         next_count = '0;
      else if (count == CW'(TIMEOUT_CYCLES - 1))
      begin
         next_count  = '0;
         next_expire = 1'b1;
      end
      else
         next_count = count + 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         count  <= '0;
         expire <= 1'b0;
      end
      else
      begin
         count  <= next_count;
         expire <= next_expire;
      end
   end
endmodule
`default_nettype wire

// file: hdl/sswd_top.sv
// Purpose: Serial command port, output steering, fault report and watchdog
// Assumes: Serial clock much slower than clock; pins except low_side_direct_in and the select inputs pass two flops first
// Notes:   Pin pull resistors are modelled as pin defaults, not logic
`timescale 1ns/1ps
`default_nettype none
// Function
// - Serial data output enabled only while chip select is low.
// - Serial data output changes only on serial clock rising edges; the code also loads the first fault bit on chip select fall.
// - Fault bits shift out MSB first, bit n is output n.
// - Commands are 16-bit words, MSB first, controlling twelve outputs.
// - Command bits 3..0 switch high-side outputs 3..0.
// - Command bits 11..4 switch low-side outputs 11..4.
// - Chip select floats high, so undriven select means deselected.
// - Serial data input floats low, undriven shifts in zero.
// - Open-drain fault flag pulled low on any fault; detail via serial bits.
// - Wake high enables the watchdog; undriven wake reads low.
// - Reset low clears configuration and faults, places standby unless in fail-safe.
// - Reset rising starts a new watchdog timeout.
// - Strap high: watchdog timeout fail-safe turns on high-side 0 and 2.
// - Strap low disables watchdog and fail-safe.
// - Missing watchdog toggle within timeout enters fail-safe.
// - Each high-side direct input drives its own output when its hs_direct_select bit is low.
// - Low-side direct input drives only the low-side outputs whose ls_direct_select bit is low.
// - Each sense channel reports first, second or sum of its pair.
// - High-side 2 stays on in fail-safe until reinitialised.
// - Toggling command bit 15 services the watchdog too.
// - Fail-safe left when reset and raised wake return low, or when strap goes low.
// - After reset, configuration acts zero; outputs whose select bit is low follow direct inputs.
// - Fault bits latch; cleared on chip select rise if fault gone.
module sswd_top
   import sswd_pkg::*;
#(
   parameter longint unsigned TIMEOUT_CYCLES = WD_TIMEOUT_CYCLES
) (
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire logic                  chip_select_n,
   input  wire logic                  serial_clock,
   input  wire logic                  serial_data_in,
   output logic                       serial_data_out,
   output logic                       serial_data_out_en,
   input  wire logic                  reset_n_pin,
   input  wire logic                  wake_in,
   input  wire logic                  failsafe_strap_in,
   input  wire logic                  watchdog_toggle_in,
   input  wire logic [NUM_HS-1:0]     high_side_direct_in,
   input  wire logic                  low_side_direct_in,
   input  wire logic [NUM_HS-1:0]     hs_direct_select,
   input  wire logic [NUM_LS-1:0]     ls_direct_select,
   input  wire logic [1:0]            sense_select_01,
   input  wire logic [1:0]            sense_select_23,
   input  wire logic [NUM_OUT-1:0]    output_fault_bit,
   output logic [NUM_HS-1:0]          high_side_output,
   output logic [NUM_LS-1:0]          low_side_output,
   output logic [1:0]                 sense_route_01,
   output logic [1:0]                 sense_route_23,
   output logic                       fault_flag_out_n,
   output logic                       fault_flag_out_en,
   output logic                       standby,
   output logic                       failsafe_active
);
   import sswd_pkg::*;

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   localparam int unsigned NSYNC = 7 + NUM_HS + NUM_OUT;
   logic [NSYNC-1:0] sync_vec;
   logic cs_n_s, sclk_s, sdi_s, rst_n_s, wake_s, strap_s, watchdog_toggle_in_s;
   logic [NUM_HS-1:0]  ihs_s;
   logic [NUM_OUT-1:0] fault_s;

   sswd_sync #(.WIDTH(NSYNC)) u_sync (
      .clock    (clock),
      .async_in ({chip_select_n, serial_clock, serial_data_in, reset_n_pin,
                  wake_in, failsafe_strap_in, watchdog_toggle_in,
                  high_side_direct_in, output_fault_bit}),
      .sync_out (sync_vec)
   );
   assign {cs_n_s, sclk_s, sdi_s, rst_n_s, wake_s, strap_s, watchdog_toggle_in_s,
           ihs_s, fault_s} = sync_vec;

   // -------------------------------------------------------------
   // Edge detection state
   // -------------------------------------------------------------
   logic cs_d, sclk_d, rst_d, watchdog_toggle_in_d, wake_d;
   logic cs_fall, cs_rise, sclk_rise, sclk_fall, rst_rise, watchdog_toggle_in_edge, wake_rise;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cs_d   <= 1'b1;
         sclk_d <= 1'b0;
         rst_d  <= 1'b0;
         watchdog_toggle_in_d <= 1'b0;
         wake_d <= 1'b0;
      end
      else
      begin
         cs_d   <= cs_n_s;
         sclk_d <= sclk_s;
         rst_d  <= rst_n_s;
         watchdog_toggle_in_d <= watchdog_toggle_in_s;
         wake_d <= wake_s;
      end
   end

   assign cs_fall   = cs_d && !cs_n_s;
   assign cs_rise   = !cs_d && cs_n_s;
   assign sclk_rise = !sclk_d && sclk_s;
   assign sclk_fall = sclk_d && !sclk_s;
   assign rst_rise  = !rst_d && rst_n_s;
   assign watchdog_toggle_in_edge = watchdog_toggle_in_d != watchdog_toggle_in_s;
   assign wake_rise = !wake_d && wake_s;

   // -------------------------------------------------------------
   // Serial shifter
   // -------------------------------------------------------------
   logic [WORD_BITS-1:0] rx_shift, next_rx_shift;
   logic [NUM_OUT-1:0]   tx_shift, next_tx_shift;
   logic [4:0]           bit_count, next_bit_count;
   logic [WORD_BITS-1:0] command, next_command;
   logic                 sdo, next_sdo;
   logic                 sdo_en, next_sdo_en;
   logic                 wd_bit_prev, next_wd_bit_prev;
   logic                 got_command, next_got_command;
   logic                 cmd_kick;
   logic [NUM_OUT-1:0]   fault_latch, next_fault_latch;

   always_comb
   begin
      next_rx_shift    = rx_shift;
      next_tx_shift    = tx_shift;
      next_bit_count   = bit_count;
      next_command     = command;
      next_sdo         = sdo;
      next_sdo_en      = !cs_n_s && rst_n_s;
      next_wd_bit_prev = wd_bit_prev;
      next_got_command = got_command;
      cmd_kick         = 1'b0;
      if (cs_fall)
      begin
         next_bit_count = '0;
         next_tx_shift  = fault_latch;
         next_sdo       = fault_latch[NUM_OUT-1];
      end
      else if (!cs_n_s)
      begin
         if (sclk_fall)
         begin
            next_rx_shift = {rx_shift[WORD_BITS-2:0], sdi_s};
            if (bit_count != 5'h1f)
               next_bit_count = bit_count + 5'h01;
         end
         if (sclk_rise && bit_count != 5'h00)
         begin
            next_tx_shift = {tx_shift[NUM_OUT-2:0], 1'b0};
            next_sdo      = tx_shift[NUM_OUT-2];
         end
      end
      if (cs_rise && bit_count == 5'(WORD_BITS))
      begin
         next_command     = rx_shift;
         next_got_command = 1'b1;
         next_wd_bit_prev = rx_shift[WD_BIT_POS];
         cmd_kick         = got_command && (rx_shift[WD_BIT_POS] != wd_bit_prev);
      end
      if (!rst_n_s)
      begin
         next_command     = CMD_RESET;
         next_got_command = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Fault latch
   // -------------------------------------------------------------
   always_comb
   begin
      next_fault_latch = fault_latch | fault_s;
      if (cs_rise)
         next_fault_latch = fault_s;
      if (!rst_n_s)
         next_fault_latch = FAULT_RESET;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rx_shift    <= '0;
         tx_shift    <= '0;
         bit_count   <= '0;
         command     <= CMD_RESET;
         sdo         <= 1'b0;
         sdo_en      <= 1'b0;
         wd_bit_prev <= 1'b0;
         got_command <= 1'b0;
         fault_latch <= FAULT_RESET;
      end
      else
      begin
         rx_shift    <= next_rx_shift;
         tx_shift    <= next_tx_shift;
         bit_count   <= next_bit_count;
         command     <= next_command;
         sdo         <= next_sdo;
         sdo_en      <= next_sdo_en;
         wd_bit_prev <= next_wd_bit_prev;
         got_command <= next_got_command;
         fault_latch <= next_fault_latch;
      end
   end

   assign serial_data_out    = sdo;
   assign serial_data_out_en = sdo_en;

   // -------------------------------------------------------------
   // Watchdog and mode
   // -------------------------------------------------------------
   sswd_mode_type mode, next_mode;
   logic          wd_expire;
   logic          wd_enable;
   logic          wake_raised, next_wake_raised;

   assign wd_enable = strap_s && (wake_s || rst_n_s) && mode == SSWD_NORMAL;

   sswd_watchdog #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_wd (
      .clock   (clock),
      .srst    (srst),
      .enable  (wd_enable),
      .restart (rst_rise || wake_rise || watchdog_toggle_in_edge || cmd_kick),
      .expire  (wd_expire)
   );

   always_comb
   begin
      next_mode        = mode;
      next_wake_raised = wake_raised || wake_s;
      case (mode)
         SSWD_SLEEP:
            if (rst_n_s || wake_s)
               next_mode = SSWD_NORMAL;
         SSWD_NORMAL:
            if (wd_expire && strap_s)
               next_mode = SSWD_FAILSAFE;
            else if (!rst_n_s && !wake_s)
               next_mode = SSWD_SLEEP;
         SSWD_FAILSAFE:
            if (!rst_n_s && (!wake_raised || !wake_s))
            begin
               next_mode        = SSWD_NORMAL;
               next_wake_raised = 1'b0;
            end
         default:
            next_mode = SSWD_SLEEP;
      endcase
      if (!strap_s && mode == SSWD_FAILSAFE)
         next_mode = SSWD_NORMAL;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         mode        <= SSWD_SLEEP;
         wake_raised <= 1'b0;
      end
      else
      begin
         mode        <= next_mode;
         wake_raised <= next_wake_raised;
      end
   end

   // -------------------------------------------------------------
   // Output steering
   // -------------------------------------------------------------
   logic [NUM_HS-1:0] next_hs;
   logic [NUM_LS-1:0] next_ls;
   logic [1:0]        next_sr01, next_sr23;
   logic              next_ff_n, next_ff_en, next_standby;

   always_comb
   begin
      for (int i = 0; i < NUM_HS; i++)
         next_hs[i] = hs_direct_select[i] ? command[HS_LSB+i] : ihs_s[i];
      for (int j = 0; j < NUM_LS; j++)
         next_ls[j] = ls_direct_select[j] ? command[LS_LSB+j]
                                          : low_side_direct_in;
      next_sr01 = sense_select_01;
      next_sr23 = sense_select_23;
      if (mode == SSWD_FAILSAFE)
      begin
         next_hs = FAILSAFE_HS_ON;
         next_ls = '0;
      end
      else if (!rst_n_s)
      begin
         next_hs = '0;
         next_ls = '0;
      end
      next_standby = !rst_n_s && mode != SSWD_FAILSAFE;
      next_ff_en   = |(fault_latch | fault_s);
      next_ff_n    = !next_ff_en;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         high_side_output  <= '0;
         low_side_output   <= '0;
         sense_route_01    <= SNS_FIRST;
         sense_route_23    <= SNS_FIRST;
         fault_flag_out_n  <= 1'b1;
         fault_flag_out_en <= 1'b0;
         standby           <= 1'b1;
         failsafe_active   <= 1'b0;
      end
      else
      begin
         high_side_output  <= next_hs;
         low_side_output   <= next_ls;
         sense_route_01    <= next_sr01;
         sense_route_23    <= next_sr23;
         fault_flag_out_n  <= next_ff_n;
         fault_flag_out_en <= next_ff_en;
         standby           <= next_standby;
         // Taken from mode so it lines up with the forced outputs and standby
         failsafe_active   <= mode == SSWD_FAILSAFE;
      end
   end
endmodule
`default_nettype wire

// file: verification/sswd_top_monitor.sv
// Purpose: Port-level checks for sswd_top
// Assumes: Pin inputs except low_side_direct_in and the select inputs pass a two-flop synchroniser first
// Notes:   Windows leave room for synchroniser latency
`timescale 1ns/1ps
`default_nettype none
module sswd_top_monitor
   import sswd_pkg::*;
#(
   parameter longint unsigned TIMEOUT_CYCLES = WD_TIMEOUT_CYCLES
) (
   input wire logic                clock,
   input wire logic                srst,
   input wire logic                chip_select_n,
   input wire logic                serial_clock,
   input wire logic                serial_data_in,
   input wire logic                serial_data_out,
   input wire logic                serial_data_out_en,
   input wire logic                reset_n_pin,
   input wire logic                wake_in,
   input wire logic                failsafe_strap_in,
   input wire logic                watchdog_toggle_in,
   input wire logic [NUM_HS-1:0]   high_side_direct_in,
   input wire logic                low_side_direct_in,
   input wire logic [NUM_HS-1:0]   hs_direct_select,
   input wire logic [NUM_LS-1:0]   ls_direct_select,
   input wire logic [1:0]          sense_select_01,
   input wire logic [1:0]          sense_select_23,
   input wire logic [NUM_OUT-1:0]  output_fault_bit,
   input wire logic [NUM_HS-1:0]   high_side_output,
   input wire logic [NUM_LS-1:0]   low_side_output,
   input wire logic [1:0]          sense_route_01,
   input wire logic [1:0]          sense_route_23,
   input wire logic                fault_flag_out_n,
   input wire logic                fault_flag_out_en,
   input wire logic                standby,
   input wire logic                failsafe_active
);
   logic [3:0] sclk_age;
   logic [3:0] next_sclk_age;
   logic       sclk_prev;
   // Cycles since the serial clock pin last rose, saturating
   always_comb
   begin
      next_sclk_age = (sclk_age == 4'hf) ? sclk_age : sclk_age + 4'h1;
      if (srst || (serial_clock && !sclk_prev))
      begin
         next_sclk_age = srst ? 4'hf : 4'h0;
      end
   end
   always_ff @(posedge clock)
   begin
      sclk_prev <= serial_clock;
      sclk_age  <= next_sclk_age;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   chk_sdo_tristate: assert property (chip_select_n [*8] |-> !serial_data_out_en)
      else $error("serial output enabled while deselected");
   chk_sdo_edge: assert property (serial_data_out_en && $past(serial_data_out_en)
      && !chip_select_n && $changed(serial_data_out) |-> sclk_age <= 4'h8)
      else $error("serial output changed away from a clock rise");
   chk_strap_off: assert property ((!failsafe_strap_in) [*8] |-> !failsafe_active)
      else $error("fail-safe active with strap low");
   chk_failsafe_out: assert property (failsafe_active && $past(failsafe_active)
      |-> high_side_output == FAILSAFE_HS_ON && low_side_output == 8'h00)
      else $error("wrong outputs in fail-safe");
   chk_fault_flag: assert property ((reset_n_pin && output_fault_bit != 12'h000) [*6]
      |-> fault_flag_out_en && !fault_flag_out_n)
      else $error("fault flag not pulled low");
   chk_standby_off: assert property ((!reset_n_pin) [*8] ##0 !failsafe_active
      |-> standby && high_side_output == 4'h0 && low_side_output == 8'h00)
      else $error("outputs or standby wrong while reset low");
   chk_direct_follow: assert property ((reset_n_pin && !failsafe_active
      && hs_direct_select == 4'h0 && ls_direct_select == 8'h00
      && $stable(high_side_direct_in) && $stable(low_side_direct_in)) [*6]
      |-> high_side_output == high_side_direct_in
      && low_side_output == {8{low_side_direct_in}})
      else $error("outputs do not follow direct inputs");
   chk_sense_route: assert property ((reset_n_pin && $stable(sense_select_01)
      && $stable(sense_select_23)) [*6]
      |-> sense_route_01 == sense_select_01 && sense_route_23 == sense_select_23)
      else $error("sense routing differs from selection");
endmodule
bind sswd_top sswd_top_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sswd_top_monitor (
   .clock(clock), .srst(srst), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
   .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
   .serial_data_out_en(serial_data_out_en), .reset_n_pin(reset_n_pin), .wake_in(wake_in),
   .failsafe_strap_in(failsafe_strap_in), .watchdog_toggle_in(watchdog_toggle_in),
   .high_side_direct_in(high_side_direct_in), .low_side_direct_in(low_side_direct_in),
   .hs_direct_select(hs_direct_select), .ls_direct_select(ls_direct_select),
   .sense_select_01(sense_select_01), .sense_select_23(sense_select_23),
   .output_fault_bit(output_fault_bit), .high_side_output(high_side_output),
   .low_side_output(low_side_output), .sense_route_01(sense_route_01),
   .sense_route_23(sense_route_23), .fault_flag_out_n(fault_flag_out_n),
   .fault_flag_out_en(fault_flag_out_en), .standby(standby),
   .failsafe_active(failsafe_active));
`default_nettype wire

// file: verification/sswd_host.sv
// Purpose: Serial master model for the switch control block
// Assumes: Serial clock period of 16 system clocks (80 ns)
// Notes:   A released data output reads as the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module sswd_host (
   input  wire logic clock,
   output var logic  chip_select_n,
   output var logic  serial_clock,
   output var logic  serial_data_in,
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_en
);
   logic so_wire;
   assign so_wire = serial_data_out_en ? serial_data_out : !serial_data_out;
   initial
   begin
      chip_select_n  = 1'b1;
      serial_clock   = 1'b0;
      serial_data_in = 1'b0;
   end
   task automatic half_period();
      repeat (8) @(posedge clock);
      #1;
   endtask
   // Word goes out MSB first; data set at the rise is valid at the fall
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [11:0] rd);
      int i;
      rd = 12'h000;
      @(posedge clock);
      #1;
      chip_select_n = 1'b0;
      half_period();
      for (i = 0; i < nbits; i++)
      begin
         serial_clock   = 1'b1;
         serial_data_in = word[15-i];
         half_period();
         if (i < 12)
         begin
            rd[11-i] = so_wire;
         end
         serial_clock = 1'b0;
         half_period();
      end
      chip_select_n  = 1'b1;
      serial_data_in = 1'b0;
      half_period();
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench for sswd_top
// Assumes: Timeout shortened to 2000 cycles
// Notes:   Expected outputs come from a reference model in the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sswd_pkg::*;
   localparam longint unsigned TMO = 2000;
   logic clock = 1'b0;
   logic srst, reset_n_pin, wake_in, failsafe_strap_in, watchdog_toggle_in;
   logic chip_select_n, serial_clock, serial_data_in, serial_data_out, serial_data_out_en;
   logic [3:0] high_side_direct_in, hs_direct_select, high_side_output;
   logic [7:0] ls_direct_select, low_side_output;
   logic low_side_direct_in, fault_flag_out_n, fault_flag_out_en, standby, failsafe_active;
   logic [1:0] sense_select_01, sense_select_23, sense_route_01, sense_route_23;
   logic [11:0] output_fault_bit, fmodel, rd;
   logic [31:0] seed, r, w;
   logic [15:0] cmd_q[$];
   int num_errors, compares, n;
   always #2.5 clock = !clock;
   sswd_top #(.TIMEOUT_CYCLES(TMO)) i_sswd_top (.*);
   sswd_host i_sswd_host (.clock(clock), .chip_select_n(chip_select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Command bit where selected, direct input elsewhere
   function automatic logic [11:0] model_out(logic [15:0] c);
      return {(ls_direct_select & c[11:4]) | (~ls_direct_select & {8{low_side_direct_in}}),
              (hs_direct_select & c[3:0]) | (~hs_direct_select & high_side_direct_in)};
   endfunction
   task automatic tick(int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic check(string name, logic [15:0] expv, logic [15:0] got);
      compares++;
      if (got !== expv)
      begin
         $display("[ERR] %s expected %h seen %h", name, expv, got);
         num_errors++;
      end
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wait_failsafe(logic lvl);
      for (n = 0; n < 4000 && failsafe_active !== lvl; n++)
         tick(1);
      if (n == 4000)
      begin
         $display("[ERR] failsafe_active expected %0d seen %0d", lvl, failsafe_active);
         num_errors++;
         end_of_test();
      end
   endtask
   initial
   begin
      {srst, seed, fmodel, num_errors, compares} = {1'b1, 32'hfa8c_6488, 12'h000, 64'h0};
      {reset_n_pin, wake_in, failsafe_strap_in, watchdog_toggle_in} = 4'h0;
      {high_side_direct_in, low_side_direct_in, hs_direct_select, ls_direct_select} = 17'h0;
      {sense_select_01, sense_select_23, output_fault_bit} = 16'h0000;
      cmd_q.push_back(CMD_RESET);
      tick(8);
      srst = 1'b0;
      tick(10);
      check("standby", 16'h0001, standby);
      reset_n_pin = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         r = rnd();
         {low_side_direct_in, high_side_direct_in} = r[4:0];
         tick(10);
         check("default outputs", model_out(16'h0000), {low_side_output, high_side_output});
      end
      check("standby", 16'h0000, standby);
      for (int k = 0; k < 8; k++)
      begin
         r = rnd();
         {low_side_direct_in, high_side_direct_in, ls_direct_select, hs_direct_select} = r[16:0];
         sense_select_01 = 2'(k % 3);
         sense_select_23 = 2'((k + 1) % 3);
         output_fault_bit = r[28:17];
         fmodel |= output_fault_bit;
         w = rnd();
         tick(8);
         i_sswd_host.xfer(w[15:0], (k == 5) ? 15 : 16, rd);
         check("fault bits", fmodel, rd);
         if (k != 5)
            cmd_q.push_back(w[15:0]);
         fmodel = output_fault_bit;
         tick(10);
         check("outputs", model_out(cmd_q[$]), {low_side_output, high_side_output});
         check("sense", {sense_select_23, sense_select_01}, {sense_route_23, sense_route_01});
         if (output_fault_bit != 12'h000)
            check("fault flag", 16'h0002, {fault_flag_out_en, fault_flag_out_n});
         else
            check("fault flag", 16'h0001, {fault_flag_out_en, fault_flag_out_n});
      end
      tick(2100);
      check("strap low", 16'h0000, failsafe_active);
      failsafe_strap_in = 1'b1;
      reset_n_pin = 1'b0;
      tick(4);
      reset_n_pin = 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         tick(1200);
         watchdog_toggle_in = !watchdog_toggle_in;
      end
      for (int k = 0; k < 8; k++)
      begin
         w = rnd();
         w[15] = k[0];
         i_sswd_host.xfer(w[15:0], 16, rd);
      end
      check("serviced", 16'h0000, failsafe_active);
      wait_failsafe(1'b1);
      check("timeout late enough", 16'h0001, n > 1500);
      tick(2);
      check("failsafe outputs", {8'h00, FAILSAFE_HS_ON}, {low_side_output, high_side_output});
      i_sswd_host.xfer(16'h0fff, 16, rd);
      tick(10);
      check("failsafe hold", {8'h00, FAILSAFE_HS_ON}, {low_side_output, high_side_output});
      reset_n_pin = 1'b0;
      tick(10);
      check("failsafe exit", 16'h0000, failsafe_active);
      wake_in = 1'b1;
      wait_failsafe(1'b1);
      check("wake timeout", 16'h0001, failsafe_active);
      wake_in = 1'b0;
      tick(10);
      check("wake exit", 16'h0000, failsafe_active);
      end_of_test();
   end
endmodule
`default_nettype wire
